// ===== dataway_ctrl_model.sv
// crate controller model driving commands and initialize
`timescale 1ns/1ps
module dataway_ctrl_model
   import scope_cmd_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     q_resp,
   output scope_cmd_pkg::dataway_cmd_type cmd,
   output logic                          dataway_init
);
   initial begin
      cmd = '0;
      dataway_init = 1'b0;
   end
   // one strobe cycle, q taken in the cycle after
   task automatic issue(input logic [4:0] f, input logic [3:0] a, input logic [3:0] w,
                        output logic q);
      @(posedge core_clk) #1;
      cmd = '{1'b1, f, a, w};
      @(posedge core_clk) #1;
      cmd = '{1'b0, ~f, ~a, ~w};
      q = q_resp;
   endtask
   // poll busy until clear before the next command
   task automatic wait_idle(input logic [3:0] a, output logic ok);
      logic q;
      ok = 1'b0;
      for (int i = 0; i < 40 && !ok; i++) begin
         issue(FN_TEST_BUSY, a, 4'h0, q);
         ok = (q === 1'b0);
      end
   endtask
   task automatic zap();
      @(posedge core_clk) #1;
      dataway_init = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 dataway_init = 1'b0;
   endtask
endmodule

// ===== group_timer.sv
// one command group: timer with busy and done flags
`timescale 1ns/1ps
module group_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic init,
   input  wire logic start,
   input  wire logic clear_done,
   output logic      busy,
   output logic      done
);
   import scope_cmd_pkg::*;
   localparam logic [TIMER_W-1:0] LAST = TIMER_W'(CYCLES - 1);
   logic [TIMER_W-1:0] count_r;
   wire                expire = busy && (count_r == LAST);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= '0;
         busy    <= 1'b0;
      end else if (init) begin
         count_r <= '0;
         busy    <= 1'b0;
      end else if (start) begin
         count_r <= '0;
         busy    <= 1'b1;
      end else if (busy) begin
         count_r <= count_r + TIMER_W'(1);
         busy    <= !expire;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) done <= 1'b0;
      else if (init) done <= 1'b0;
      else if (expire) done <= 1'b1;
      else if (clear_done || start) done <= 1'b0;
   end
endmodule

// ===== scope_cmd_asserts.sv
// assertions on the command timer ports
`timescale 1ns/1ps
module scope_cmd_asserts
   import scope_cmd_pkg::*;
(
   input wire logic                           core_clk,
   input wire logic                           rst,
   input wire logic                           dataway_init,
   input wire scope_cmd_pkg::dataway_cmd_type cmd,
   input wire logic                           q_resp,
   input wire logic                           look_at_me,
   input wire scope_cmd_pkg::scope_ctrl_type  scope_ctrl,
   input wire logic [3:0]                     busy_flags,
   input wire logic [3:0]                     done_flags
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire tk = cmd.strobe && !dataway_init;
   wire md = tk && (cmd.func == FN_SET_MODE || cmd.func == FN_CLEAR_MODE);
   wire act = tk && cmd.func == FN_ACTION;
   a_store_mode: assert property (md && cmd.subaddr == 4'h0 |=>
      scope_ctrl.store_mode == ($past(cmd.func) == FN_SET_MODE)) else $error("store mode");
   a_wthru_mode: assert property (md && cmd.subaddr == 4'h1 |=>
      scope_ctrl.write_thru_mode == ($past(cmd.func) == FN_SET_MODE)) else $error("wthru mode");
   a_erase_req: assert property (act && cmd.subaddr == 4'h0 |=> ##[0:1] scope_ctrl.erase_req)
      else $error("erase req missing");
   a_view_pulse: assert property (act && cmd.subaddr == 4'h1 |=> scope_ctrl.view_req)
      else $error("view req missing");
   a_scope_q: assert property ((md || act) && cmd.subaddr < 4'h2 |=> q_resp)
      else $error("no q on scope command");
   a_mask_q: assert property (tk && cmd.func == FN_WRITE_MASK && cmd.subaddr == 4'h0 |=> q_resp)
      else $error("no q on mask write");
   a_q_cause: assert property (q_resp |-> $past(cmd.strobe))
      else $error("q without strobe");
   a_done_on_end: assert property (!$past(dataway_init) |->
      ($past(busy_flags) & ~busy_flags & ~done_flags) == 4'h0) else $error("no done at end");
   a_lam_cause: assert property (look_at_me |-> |(done_flags | $past(done_flags)))
      else $error("lam without done");
   a_init_ctrl: assert property (dataway_init |=> scope_ctrl == '0 && !look_at_me)
      else $error("init left ctrl");
   a_init_flags: assert property (dataway_init [*2] |=> (busy_flags | done_flags) == 4'h0)
      else $error("init left flags");
endmodule

// ===== scope_cmd_pkg.sv
// package: function codes, sub-addresses, timing and carrier types
package scope_cmd_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam logic [4:0]  FN_TEST_DONE    = 5'h08;
   localparam logic [4:0]  FN_CLEAR_DONE   = 5'h0A;
   localparam logic [4:0]  FN_WRITE_MASK   = 5'h10;
   localparam logic [4:0]  FN_CLEAR_MODE   = 5'h18;
   localparam logic [4:0]  FN_SET_MODE     = 5'h1A;
   localparam logic [4:0]  FN_TEST_BUSY    = 5'h1B;
   localparam logic [4:0]  FN_ACTION       = 5'h1C;
   localparam logic [3:0]  SA_STORE        = 4'h0;
   localparam logic [3:0]  SA_WRITE_THRU   = 4'h1;
   localparam logic [3:0]  SA_ERASE        = 4'h2;
   localparam logic [3:0]  SA_VIEW         = 4'h3;
   localparam int unsigned GROUPS          = 4;
   localparam int unsigned STORE_TIME_MS   = 100;
   localparam int unsigned ERASE_TIME_MS   = 500;
   localparam int unsigned WTHRU_TIME_MS   = 100;
   localparam int unsigned VIEW_TIME_MS    = 100;
   localparam int unsigned STORE_CYCLES    = STORE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned ERASE_CYCLES    = ERASE_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned WTHRU_CYCLES    = WTHRU_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned VIEW_CYCLES     = VIEW_TIME_MS * (CLK_HZ / 1000);
   localparam int unsigned TIMER_W         = 28;
   localparam logic [3:0]  MASK_RESET      = 4'h0;
   localparam logic        MODE_RESET      = 1'b0;

   typedef struct packed {
      logic       strobe;
      logic [4:0] func;
      logic [3:0] subaddr;
      logic [3:0] wdata;
   } dataway_cmd_type;

   typedef struct packed {
      logic store_mode;
      logic write_thru_mode;
      logic erase_req;
      logic view_req;
   } scope_ctrl_type;
endpackage

// ===== storage_scope_command_timer.sv
// top: dataway command decode, timers, masks and q response
`timescale 1ns/1ps
// Functional notes
// - F26/F24 A0 set/clear storing mode
// - F26/F24 A1 set/clear write-through mode
// - F28 A0 erase half second, A1 view
// - storing timer done 0.1 s after release
// - per-group timer, busy set, done on completion
// - scope commands give Q, start group timer
// - F27 tests busy flag by sub-address
// - busy test ignores enable mask
// - F8 tests done request by sub-address
// - F10 tests like F8, then clears done
// - F8/F10 Q needs done and enable
// - F16 A0 loads mask from W1-W4, Q
// - initialize clears modes, flags, mask
module storage_scope_command_timer #(
   parameter int unsigned STORE_CYC = scope_cmd_pkg::STORE_CYCLES,
   parameter int unsigned WTHRU_CYC = scope_cmd_pkg::WTHRU_CYCLES,
   parameter int unsigned ERASE_CYC = scope_cmd_pkg::ERASE_CYCLES,
   parameter int unsigned VIEW_CYC  = scope_cmd_pkg::VIEW_CYCLES
) (
   input  wire logic                          core_clk,
   input  wire logic                          rst,
   input  wire logic                          dataway_init,
   input  wire scope_cmd_pkg::dataway_cmd_type cmd,
   output logic                               q_resp,
   output logic                               look_at_me,
   output scope_cmd_pkg::scope_ctrl_type      scope_ctrl,
   output logic [3:0]                         busy_flags,
   output logic [3:0]                         done_flags
);
   import scope_cmd_pkg::*;

   // state registers and their next values
   logic [3:0] done_request_enable_mask_r;
   logic [3:0] done_request_enable_mask_nxt;
   logic       store_mode_r;
   logic       store_mode_nxt;
   logic       wthru_mode_r;
   logic       wthru_mode_nxt;
   logic       erase_req_r;
   logic       erase_req_nxt;
   logic       view_req_r;
   logic       view_req_nxt;
   logic       q_r;
   logic       q_nxt;
   logic       lam_r;
   logic       lam_nxt;
   logic [3:0] busy_flags_r;
   logic [3:0] busy_flags_nxt;
   logic [3:0] done_flags_r;
   logic [3:0] done_flags_nxt;
   logic [3:0] busy_w;
   logic [3:0] done_w;

   // decode terms
   logic       sa_ok;
   logic [1:0] sel;
   logic [3:0] grp_sel_w;
   logic       is_set;
   logic       is_clr;
   logic       is_act;
   logic       is_mode;
   logic       is_actn;
   logic       is_busy;
   logic       is_tst;
   logic       is_tclr;
   logic       is_any_tst;
   logic       is_mask;
   logic       set_store;
   logic       clr_store;
   logic       set_wthru;
   logic       clr_wthru;
   logic       start_store;
   logic       start_wthru;
   logic       do_erase;
   logic       do_view;
   logic [3:0] start_w;
   logic [3:0] clr_done_w;
   logic [3:0] pending_w;
   logic       lam_hit;
   logic       q_cmd_w;
   logic       q_busy_w;
   logic       q_done_w;

   // command decode
   assign sa_ok      = cmd.subaddr < 4'h4;
   assign sel        = cmd.subaddr[1:0];
   assign grp_sel_w  = 4'h1 << sel;
   assign is_set     = cmd.strobe && cmd.func == FN_SET_MODE;
   assign is_clr     = cmd.strobe && cmd.func == FN_CLEAR_MODE;
   assign is_act     = cmd.strobe && cmd.func == FN_ACTION;
   assign is_mode    = (is_set || is_clr) && cmd.subaddr <= SA_WRITE_THRU;
   assign is_actn    = is_act && cmd.subaddr <= SA_WRITE_THRU;
   assign is_busy    = cmd.strobe && cmd.func == FN_TEST_BUSY && sa_ok;
   assign is_tst     = cmd.strobe && cmd.func == FN_TEST_DONE && sa_ok;
   assign is_tclr    = cmd.strobe && cmd.func == FN_CLEAR_DONE && sa_ok;
   assign is_any_tst = is_tst || is_tclr;
   assign is_mask    = cmd.strobe && cmd.func == FN_WRITE_MASK && cmd.subaddr == SA_STORE;
   assign set_store  = is_set && cmd.subaddr == SA_STORE;
   assign clr_store  = is_clr && cmd.subaddr == SA_STORE;
   assign set_wthru  = is_set && cmd.subaddr == SA_WRITE_THRU;
   assign clr_wthru  = is_clr && cmd.subaddr == SA_WRITE_THRU;
   assign do_erase   = is_actn && cmd.subaddr == SA_STORE;
   assign do_view    = is_actn && cmd.subaddr == SA_WRITE_THRU;

   // timer starts on the command strobe; store settles once released
   assign start_store = set_store || clr_store;
   assign start_wthru = set_wthru || clr_wthru;
   assign start_w     = {do_view,
                         do_erase,
                         start_wthru,
                         start_store};
   assign clr_done_w  = is_tclr ? grp_sel_w : 4'h0;
   assign pending_w   = done_w & done_request_enable_mask_r;
   assign lam_hit     = pending_w[sel];

   // q sources: scope commands, mask write, busy test, done tests
   assign q_cmd_w    = is_mode || is_actn || is_mask;
   assign q_busy_w   = is_busy && busy_w[sel];
   assign q_done_w   = is_any_tst && lam_hit;
   assign q_nxt      = q_cmd_w
                       || q_busy_w
                       || q_done_w;
   assign lam_nxt    = !dataway_init && |pending_w;

   // erase held for its timer, view a one-cycle request
   assign erase_req_nxt  = !dataway_init
                           && (do_erase || (erase_req_r && busy_w[2]));
   assign view_req_nxt   = !dataway_init && do_view;
   assign busy_flags_nxt = busy_w;
   assign done_flags_nxt = done_w;

   always_comb begin
      store_mode_nxt = store_mode_r;
      if (dataway_init) begin
         store_mode_nxt = MODE_RESET;
      end else if (set_store) begin
         store_mode_nxt = 1'b1;
      end else if (clr_store) begin
         store_mode_nxt = 1'b0;
      end
   end

   always_comb begin
      wthru_mode_nxt = wthru_mode_r;
      if (dataway_init) begin
         wthru_mode_nxt = MODE_RESET;
      end else if (set_wthru) begin
         wthru_mode_nxt = 1'b1;
      end else if (clr_wthru) begin
         wthru_mode_nxt = 1'b0;
      end
   end

   always_comb begin
      done_request_enable_mask_nxt = done_request_enable_mask_r;
      if (dataway_init) begin
         done_request_enable_mask_nxt = MASK_RESET;
      end else if (is_mask) begin
         done_request_enable_mask_nxt = cmd.wdata;
      end
   end

   // storing mode group
   group_timer #(
      .CYCLES(STORE_CYC)
   ) u_store (
      .clk        (core_clk),
      .rst        (rst),
      .init       (dataway_init),
      .start      (start_w[0]),
      .clear_done (clr_done_w[0]),
      .busy       (busy_w[0]),
      .done       (done_w[0])
   );

   // write-through mode group
   group_timer #(
      .CYCLES(WTHRU_CYC)
   ) u_wthru (
      .clk        (core_clk),
      .rst        (rst),
      .init       (dataway_init),
      .start      (start_w[1]),
      .clear_done (clr_done_w[1]),
      .busy       (busy_w[1]),
      .done       (done_w[1])
   );

   // erase group
   group_timer #(
      .CYCLES(ERASE_CYC)
   ) u_erase (
      .clk        (core_clk),
      .rst        (rst),
      .init       (dataway_init),
      .start      (start_w[2]),
      .clear_done (clr_done_w[2]),
      .busy       (busy_w[2]),
      .done       (done_w[2])
   );

   // view group
   group_timer #(
      .CYCLES(VIEW_CYC)
   ) u_view (
      .clk        (core_clk),
      .rst        (rst),
      .init       (dataway_init),
      .start      (start_w[3]),
      .clear_done (clr_done_w[3]),
      .busy       (busy_w[3]),
      .done       (done_w[3])
   );

   // registered state and outputs
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done_request_enable_mask_r <= MASK_RESET;
      end else begin
         done_request_enable_mask_r <= done_request_enable_mask_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         store_mode_r <= MODE_RESET;
      end else begin
         store_mode_r <= store_mode_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         wthru_mode_r <= MODE_RESET;
      end else begin
         wthru_mode_r <= wthru_mode_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         erase_req_r <= 1'b0;
      end else begin
         erase_req_r <= erase_req_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         view_req_r <= 1'b0;
      end else begin
         view_req_r <= view_req_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         q_r <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         lam_r <= 1'b0;
      end else begin
         lam_r <= lam_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         busy_flags_r <= 4'h0;
      end else begin
         busy_flags_r <= busy_flags_nxt;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         done_flags_r <= 4'h0;
      end else begin
         done_flags_r <= done_flags_nxt;
      end
   end

   assign q_resp     = q_r;
   assign look_at_me = lam_r;
   assign busy_flags = busy_flags_r;
   assign done_flags = done_flags_r;
   assign scope_ctrl = '{store_mode:      store_mode_r,
                         write_thru_mode: wthru_mode_r,
                         erase_req:       erase_req_r,
                         view_req:        view_req_r};
endmodule

// ===== testbench.sv
// self-checking bench for the command timer
`timescale 1ns/1ps
module testbench;
   import scope_cmd_pkg::*;
   localparam int         DUR [4] = '{8, 6, 8, 5};
   localparam logic [4:0] GF [4]  = '{FN_SET_MODE, FN_SET_MODE, FN_ACTION, FN_ACTION};
   logic            core_clk, rst, q_resp, look_at_me, q, ok, dataway_init;
   dataway_cmd_type cmd;
   scope_ctrl_type  scope_ctrl;
   logic [3:0]      busy_flags, done_flags;
   logic [15:0]     n;
   int              mismatches = 0;
   int              num_checks = 0;
   storage_scope_command_timer #(.STORE_CYC(DUR[0]), .WTHRU_CYC(DUR[1]), .ERASE_CYC(DUR[2]),
      .VIEW_CYC(DUR[3])) dut_u (.core_clk(core_clk), .rst(rst), .dataway_init(dataway_init),
      .cmd(cmd), .q_resp(q_resp), .look_at_me(look_at_me), .scope_ctrl(scope_ctrl),
      .busy_flags(busy_flags), .done_flags(done_flags));
   dataway_ctrl_model ctl_u (.core_clk(core_clk), .q_resp(q_resp), .cmd(cmd),
      .dataway_init(dataway_init));
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic cq(input logic [4:0] f, input logic [3:0] a, input logic [3:0] w,
                     input logic e);
      ctl_u.issue(f, a, w, q);
      check("q_resp", q, e);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge core_clk);
      #1 rst = 1'b0;
      check("ctrl", {scope_ctrl, busy_flags, done_flags}, 16'h0);
      cq(FN_WRITE_MASK, 4'h0, 4'hF, 1'b1);
      for (int g = 0; g < 4; g++) begin
         cq(GF[g], 4'(g % 2), 4'h0, 1'b1);
         cq(FN_TEST_BUSY, 4'(g), 4'h0, 1'b1);
         n = 16'h1;
         for (int i = 0; i < 64 && busy_flags[g] === 1'b1; i++) begin
            n++;
            @(posedge core_clk) #1;
         end
         check("busy_len", n, 16'(DUR[g]));
         if (busy_flags[g] === 1'b1) end_of_test();
         check("done", done_flags[g], 1'b1);
         @(posedge core_clk) #1;
         check("lam", look_at_me, 1'b1);
         cq(FN_TEST_DONE, 4'(g), 4'h0, 1'b1);
         cq(FN_CLEAR_DONE, 4'(g), 4'h0, 1'b1);
         cq(FN_TEST_DONE, 4'(g), 4'h0, 1'b0);
      end
      check("modes", {scope_ctrl.store_mode, scope_ctrl.write_thru_mode}, 2'b11);
      cq(FN_ACTION, 4'h1, 4'h0, 1'b1);
      check("view", scope_ctrl.view_req, 1'b1);
      ctl_u.wait_idle(4'h3, ok);
      check("idle", ok, 1'b1);
      cq(FN_WRITE_MASK, 4'h0, 4'h0, 1'b1);
      cq(FN_CLEAR_MODE, 4'h0, 4'h0, 1'b1);
      check("store", scope_ctrl.store_mode, 1'b0);
      cq(FN_TEST_BUSY, 4'h0, 4'h0, 1'b1);
      ctl_u.wait_idle(4'h0, ok);
      check("idle", ok, 1'b1);
      if (!ok) end_of_test();
      cq(FN_TEST_DONE, 4'h0, 4'h0, 1'b0);
      check("done", done_flags, 4'h9);
      check("lam", look_at_me, 1'b0);
      cq(FN_WRITE_MASK, 4'h0, 4'h1, 1'b1);
      @(posedge core_clk) #1;
      check("lam", look_at_me, 1'b1);
      cq(FN_TEST_DONE, 4'h4, 4'h0, 1'b0);
      cq(5'h05, 4'h0, 4'h0, 1'b0);
      cq(FN_ACTION, 4'h0, 4'h0, 1'b1);
      check("erase", scope_ctrl.erase_req, 1'b1);
      ctl_u.zap();
      @(posedge core_clk) #1;
      check("init", {scope_ctrl, busy_flags, done_flags, 3'h0, look_at_me}, 16'h0);
      cq(FN_TEST_BUSY, 4'h2, 4'h0, 1'b0);
      end_of_test();
   end
endmodule
bind storage_scope_command_timer scope_cmd_asserts chk_u (.core_clk(core_clk), .rst(rst),
   .dataway_init(dataway_init), .cmd(cmd), .q_resp(q_resp), .look_at_me(look_at_me),
   .scope_ctrl(scope_ctrl), .busy_flags(busy_flags), .done_flags(done_flags));
